// [interval_timer_pkg.sv]
// Package for the three-channel interval timer: port offsets, command fields, constants.
// Assumes a byte-wide I/O port access from the host on the register clock.
package interval_timer_pkg;
    localparam logic [7:0] counter0_data_port  = 8'h40;
    localparam logic [7:0] counter1_data_port  = 8'h41;
    localparam logic [7:0] counter2_data_port  = 8'h42;
    localparam logic [7:0] timer_command_port  = 8'h43;
    localparam int         REG_CLK_KHZ         = 14318;
    localparam int         TICK_DIV            = 12;
    localparam logic [3:0] TICK_DIV_LAST       = 4'hb;
    localparam logic [1:0] SEL_READBACK        = 2'h3;
    localparam logic [1:0] FMT_LATCH           = 2'h0;
    localparam logic [1:0] FMT_LSB             = 2'h1;
    localparam logic [1:0] FMT_MSB             = 2'h2;
    localparam logic [1:0] FMT_BOTH            = 2'h3;
    localparam logic [2:0] MODE_RESET          = 3'h0;
    localparam logic [5:0] CTRL_RESET          = 6'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;
endpackage : interval_timer_pkg

// [interval_timer.sv]
// Three 16-bit down-counters behind byte-wide I/O ports, counter 2 drives the speaker.
// Assumes host I/O strobes synchronous to mclk_in, one cycle each; read data valid next cycle.
// Contract
// - Counter 2 output is the speaker tone, tick rate divided by initial count.
// - Speaker carries the tone only while speaker gate enable is set.
// - Byte format selects LSB, MSB or LSB-then-MSB for reads and writes.
// - New count keeps the mode; applied per the mode's rules.
// - One command port takes control word, latch and read-back commands.
// - Mode 0: output low, rises at zero, stays high until reprogrammed.
// - Mode 1: output low, high for one tick at zero.
// - Mode 2: output high, low for one tick at terminal count, reload.
// - Mode 3: output starts high, toggles and reloads at each rollover.
// - Modes 4 and 5: output high, low one tick when count expires.
// - Each counter has its own data port at consecutive addresses.
// - Byte sequences of each counter are independent of other counters.
// - Clearing tone counter gate enable stops counter 2.
// - Latch captures live count, counting continues, held until read or reprogram.
// - Second latch before the read is ignored.
// - Read-back latches count and/or status for all selected counters.
// - Repeated status or count latches without a read are ignored.
// - Status read first, then latched count bytes, then live count.
// - Square wave decrements by two per tick, reloads at zero.
// - All registers run on the register clock, tick derived from it.
// - Platform reset drives the speaker output low.
module interval_timer (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_addr_in,
    input  wire logic [7:0] io_wdata_in,
    input  wire logic       speaker_gate_enable_in,
    input  wire logic       tone_counter_gate_enable_in,
    output logic      [7:0] io_rdata_out,
    output logic      [2:0] timer_out_out,
    output logic            speaker_tone_output_out
);
    interval_timer_pkg::io_req_t req;
    assign req = '{wr: io_wr_in, rd: io_rd_in, addr: io_addr_in, wdata: io_wdata_in};

    function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd, input logic [15:0] step);
        logic [15:0] r;
        r = v - step;
        if (bcd) begin
            // Step through decimal digits; a wrap below zero lands on 9999
            r = v;
            for (int k = 0; k < 2; k++) begin
                if (k < int'(step)) begin
                    if (r[3:0] != 4'h0) r[3:0] = r[3:0] - 4'h1;
                    else begin
                        r[3:0] = 4'h9;
                        if (r[7:4] != 4'h0) r[7:4] = r[7:4] - 4'h1;
                        else begin
                            r[7:4] = 4'h9;
                            if (r[11:8] != 4'h0) r[11:8] = r[11:8] - 4'h1;
                            else begin
                                r[11:8]  = 4'h9;
                                r[15:12] = (r[15:12] != 4'h0) ? r[15:12] - 4'h1 : 4'h9;
                            end
                        end
                    end
                end
            end
        end
        return r;
    endfunction : dec_count

    logic [3:0]  div_ff, nxt_div;
    logic        tick_ff, nxt_tick;
    logic [2:0]  g0_ff, g1_ff;
    logic        gate_run;

    always_comb begin
        nxt_div  = (div_ff == interval_timer_pkg::TICK_DIV_LAST) ? 4'h0 : div_ff + 4'h1;
        nxt_tick = (div_ff == interval_timer_pkg::TICK_DIV_LAST);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            div_ff  <= 4'h0;
            tick_ff <= 1'b0;
            g0_ff   <= 3'h0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
            g0_ff   <= {g0_ff[1:0], tone_counter_gate_enable_in};
        end
    end
    // Gate counts as set once the second and third stages agree
    logic gate_ff, nxt_gate;
    logic spk_sync_ff, nxt_spk;
    always_comb begin
        nxt_gate = (g0_ff[2] == g0_ff[1]) ? g0_ff[2] : gate_ff;
        nxt_spk  = (g1_ff[2] == g1_ff[1]) ? g1_ff[2] : spk_sync_ff;
    end
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            g1_ff <= 3'h0; gate_ff <= 1'b0; spk_sync_ff <= 1'b0;
        end else begin
            g1_ff <= {g1_ff[1:0], speaker_gate_enable_in};
            gate_ff <= nxt_gate; spk_sync_ff <= nxt_spk;
        end
    end
    assign gate_run = gate_ff;

    // Cycles since the last tick; a counter sees the whole spacing, a repetition only part of it
    logic [3:0]  gap_ff, nxt_gap;
    always_comb begin
        nxt_gap = tick_ff ? 4'h1 : gap_ff + 4'h1;
    end
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            gap_ff <= 4'h0;
        end else begin
            gap_ff <= nxt_gap;
        end
    end

    // Per-counter state
    logic [5:0]  ctrl_ff   [3], nxt_ctrl   [3];   // {fmt[1:0], mode[2:0], bcd}
    logic [15:0] init_ff   [3], nxt_init   [3];
    logic [15:0] cnt_ff    [3], nxt_cnt    [3];
    logic [15:0] olat_ff   [3], nxt_olat   [3];
    logic [7:0]  stat_ff   [3], nxt_stat   [3];
    logic        cl_ff     [3], nxt_cl     [3];
    logic        sl_ff     [3], nxt_sl     [3];
    logic        rmsb_ff   [3], nxt_rmsb   [3];
    logic        wmsb_ff   [3], nxt_wmsb   [3];
    logic        null_ff   [3], nxt_null   [3];
    logic        load_ff   [3], nxt_load   [3];
    logic        arm_ff    [3], nxt_arm    [3];
    logic        out_ff    [3], nxt_out    [3];
    logic [7:0]  nxt_rdata;

    always_comb begin
        logic [1:0]  sel, fmt;
        logic [2:0]  md;
        logic [15:0] src, step;
        logic        hit, done;
        sel = req.wdata[7:6]; fmt = 2'h0; md = 3'h0; src = 16'h0; step = 16'h1; hit = 1'b0; done = 1'b0;
        nxt_rdata = 8'h00;
        for (int i = 0; i < 3; i++) begin
            nxt_ctrl[i] = ctrl_ff[i]; nxt_init[i] = init_ff[i]; nxt_cnt[i] = cnt_ff[i];
            nxt_olat[i] = olat_ff[i]; nxt_stat[i] = stat_ff[i]; nxt_cl[i] = cl_ff[i];
            nxt_sl[i] = sl_ff[i]; nxt_rmsb[i] = rmsb_ff[i]; nxt_wmsb[i] = wmsb_ff[i];
            nxt_null[i] = null_ff[i]; nxt_load[i] = load_ff[i]; nxt_arm[i] = arm_ff[i];
            nxt_out[i] = out_ff[i];
            fmt = ctrl_ff[i][5:4];
            md  = ctrl_ff[i][3:1];
            hit = (req.addr == interval_timer_pkg::counter0_data_port + 8'(i));
            // Counting on each tick; counter 2 halts with its gate clear
            if (tick_ff && (i != 2 || gate_run)) begin
                if (load_ff[i]) begin
                    nxt_cnt[i]  = (md[1:0] == 2'h3) ? {init_ff[i][15:1], 1'b0} : init_ff[i];
                    nxt_load[i] = 1'b0;
                    nxt_null[i] = 1'b0;
                    nxt_arm[i]  = 1'b1;
                    if (md == 3'h1) nxt_out[i] = 1'b0;
                end else begin
                    step = (md[1:0] == 2'h3) ? 16'h2 : 16'h1;
                    nxt_cnt[i] = dec_count(cnt_ff[i], ctrl_ff[i][0], step);
                    done = (cnt_ff[i] == step) || (cnt_ff[i] == 16'h0 && step == 16'h2);
                    if (md[1:0] == 2'h2) begin
                        nxt_out[i] = !(cnt_ff[i] == 16'h2);
                        if (cnt_ff[i] == 16'h1) nxt_cnt[i] = init_ff[i];
                    end else if (md[1:0] == 2'h3) begin
                        if (done) begin
                            nxt_out[i] = !out_ff[i];
                            nxt_cnt[i] = {init_ff[i][15:1], 1'b0};
                        end
                    end else if (md == 3'h0) begin
                        if (done) nxt_out[i] = 1'b1;
                    end else if (md == 3'h1) begin
                        nxt_out[i] = done && arm_ff[i];
                        if (done) nxt_arm[i] = 1'b0;
                    end else begin
                        nxt_out[i] = !(done && arm_ff[i]);
                        if (done) nxt_arm[i] = 1'b0;
                    end
                end
            end
            // Host writes to the data port; mode is untouched
            if (req.wr && hit) begin
                if (fmt == interval_timer_pkg::FMT_LSB) begin
                    nxt_init[i] = {8'h00, req.wdata}; nxt_load[i] = 1'b1; nxt_null[i] = 1'b1;
                end else if (fmt == interval_timer_pkg::FMT_MSB) begin
                    nxt_init[i] = {req.wdata, 8'h00}; nxt_load[i] = 1'b1; nxt_null[i] = 1'b1;
                end else if (!wmsb_ff[i]) begin
                    nxt_init[i][7:0] = req.wdata; nxt_wmsb[i] = 1'b1;
                    if (md == 3'h0) nxt_out[i] = 1'b0;
                end else begin
                    nxt_init[i][15:8] = req.wdata; nxt_wmsb[i] = 1'b0;
                    nxt_load[i] = 1'b1; nxt_null[i] = 1'b1;
                end
            end
            // Host reads: status first, then latched or live count bytes
            src = cl_ff[i] ? olat_ff[i] : cnt_ff[i];
            if (req.rd && hit) begin
                if (sl_ff[i]) begin
                    nxt_rdata = stat_ff[i]; nxt_sl[i] = 1'b0;
                end else begin
                    if (fmt == interval_timer_pkg::FMT_MSB) nxt_rdata = src[15:8];
                    else if (fmt == interval_timer_pkg::FMT_BOTH && rmsb_ff[i]) nxt_rdata = src[15:8];
                    else nxt_rdata = src[7:0];
                    if (fmt == interval_timer_pkg::FMT_BOTH && !rmsb_ff[i]) nxt_rmsb[i] = 1'b1;
                    else begin
                        nxt_rmsb[i] = 1'b0; nxt_cl[i] = 1'b0;
                    end
                end
            end
            // Command port
            if (req.wr && req.addr == interval_timer_pkg::timer_command_port) begin
                if (sel == interval_timer_pkg::SEL_READBACK) begin
                    if (req.wdata[1 + i]) begin
                        if (!req.wdata[5] && !cl_ff[i]) begin
                            nxt_cl[i] = 1'b1; nxt_olat[i] = cnt_ff[i];
                        end
                        if (!req.wdata[4] && !sl_ff[i]) begin
                            nxt_sl[i] = 1'b1;
                            nxt_stat[i] = {out_ff[i], null_ff[i], ctrl_ff[i]};
                        end
                    end
                end else if (sel == 2'(i)) begin
                    if (req.wdata[5:4] == interval_timer_pkg::FMT_LATCH) begin
                        if (!cl_ff[i]) begin
                            nxt_cl[i] = 1'b1; nxt_olat[i] = cnt_ff[i];
                        end
                    end else begin
                        nxt_ctrl[i] = req.wdata[5:0];
                        nxt_cl[i] = 1'b0; nxt_sl[i] = 1'b0; nxt_rmsb[i] = 1'b0; nxt_wmsb[i] = 1'b0;
                        nxt_null[i] = 1'b1; nxt_load[i] = 1'b0; nxt_arm[i] = 1'b0;
                        nxt_out[i] = (req.wdata[3:1] != 3'h0) && (req.wdata[3:1] != 3'h1);
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= interval_timer_pkg::CTRL_RESET; init_ff[i] <= 16'h0; cnt_ff[i] <= 16'h0;
                olat_ff[i] <= 16'h0; stat_ff[i] <= 8'h00; cl_ff[i] <= 1'b0; sl_ff[i] <= 1'b0;
                rmsb_ff[i] <= 1'b0; wmsb_ff[i] <= 1'b0; null_ff[i] <= 1'b1; load_ff[i] <= 1'b0;
                arm_ff[i] <= 1'b0; out_ff[i] <= 1'b0;
            end
            io_rdata_out            <= 8'h00;
            timer_out_out           <= 3'h0;
            speaker_tone_output_out <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= nxt_ctrl[i]; init_ff[i] <= nxt_init[i]; cnt_ff[i] <= nxt_cnt[i];
                olat_ff[i] <= nxt_olat[i]; stat_ff[i] <= nxt_stat[i]; cl_ff[i] <= nxt_cl[i];
                sl_ff[i] <= nxt_sl[i]; rmsb_ff[i] <= nxt_rmsb[i]; wmsb_ff[i] <= nxt_wmsb[i];
                null_ff[i] <= nxt_null[i]; load_ff[i] <= nxt_load[i]; arm_ff[i] <= nxt_arm[i];
                out_ff[i] <= nxt_out[i];
            end
            io_rdata_out            <= nxt_rdata;
            timer_out_out           <= {nxt_out[2], nxt_out[1], nxt_out[0]};
            speaker_tone_output_out <= nxt_out[2] && spk_sync_ff;
        end
    end

    // Checks
    a_spk_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !spk_sync_ff |=> !speaker_tone_output_out) else $error("speaker active without gate");
    a_tick_div: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        tick_ff |=> !tick_ff [*8] ##0 1'b1) else $error("tick spacing wrong");
    a_c2_frozen: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!gate_run && !(req.wr && req.addr == interval_timer_pkg::counter2_data_port)) |=> cnt_ff[2] == $past(cnt_ff[2]))
        else $error("counter 2 moved while stopped");
    a_latch_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (cl_ff[0] && !(req.rd || req.wr)) |=> olat_ff[0] == $past(olat_ff[0]))
        else $error("latched count changed");
    a_m0_high: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ctrl_ff[0][3:1] == 3'h0 && out_ff[0] && !req.wr) |=> out_ff[0]) else $error("mode 0 output fell");
    a_m2_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ctrl_ff[1][2:1] == 2'h2 && $fell(out_ff[1]) && !req.wr) |-> ##[1:12] out_ff[1])
        else $error("mode 2 low too long");
    a_status_first: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (sl_ff[0] && req.rd && req.addr == interval_timer_pkg::counter0_data_port) |=> io_rdata_out == $past(stat_ff[0]))
        else $error("status not read first");
    a_null_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (req.wr && req.addr == interval_timer_pkg::timer_command_port && req.wdata[7:6] == 2'h0 && req.wdata[5:4] != 2'h0)
        |=> null_ff[0]) else $error("null count not set");
    a_tick_gap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (tick_ff && gap_ff != 4'h0) |-> gap_ff == 4'(interval_timer_pkg::TICK_DIV))
        else $error("tick period not twelve");
    a_null_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (tick_ff && load_ff[0] && !req.wr) |=> !null_ff[0]) else $error("null count stuck");
    // Counter 2 output only moves on a tick or a host write, never between
    a_out_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!tick_ff && !req.wr) |=> $stable(out_ff[2])) else $error("output moved off tick");
    a_rdata_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !req.rd |=> io_rdata_out == 8'h00) else $error("read data without a read");
    // No disable here: the check is about the reset itself
    a_spk_reset: assert property (@(posedge mclk_in)
        !rst_n_in |=> !speaker_tone_output_out) else $error("speaker not low in reset");
endmodule : interval_timer

// [io_host_model.sv]
// Host processor model issuing byte-wide I/O port reads and writes to the timer.
// Assumes one-cycle strobes and read data valid in the cycle after the read edge.
module io_host_model (
    input  wire logic                       clk_in,
    input  wire logic                 [7:0] rdata_in,
    output interval_timer_pkg::io_req_t     req_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial req_out = '0;

    // Released address and data show the inverse so stale values are never mistaken for live ones
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr_byte

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(negedge clk_in);
        d = rdata_in;
    endtask : rd_byte

    task automatic rd_word(input logic [1:0] ctr, output logic [15:0] v);
        rd_byte(interval_timer_pkg::counter0_data_port + {6'h00, ctr}, v[7:0]);
        rd_byte(interval_timer_pkg::counter0_data_port + {6'h00, ctr}, v[15:8]);
    endtask : rd_word

    // Both count bytes follow the control word in this one routine, never split by another writer
    task automatic program_counter(input logic [1:0] ctr, input logic [2:0] mode, input logic [15:0] cnt);
        wr_byte(interval_timer_pkg::timer_command_port, {ctr, interval_timer_pkg::FMT_BOTH, mode, 1'b0});
        wr_byte(interval_timer_pkg::counter0_data_port + {6'h00, ctr}, cnt[7:0]);
        wr_byte(interval_timer_pkg::counter0_data_port + {6'h00, ctr}, cnt[15:8]);
    endtask : program_counter
endmodule : io_host_model

// [testbench.sv]
// Self-checking bench for the three-channel interval timer.
// Assumes the host model drives the I/O strobes; gates are driven here as plain levels.
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        mclk, rst_n, spk_en, tone_en, spk;
    interval_timer_pkg::io_req_t req;
    logic                  [7:0] rdata, st;
    logic                  [2:0] tout;
    logic                  [3:0] sig;
    logic                 [15:0] v1, v2;
    int                          num_errors = 0, total_checks = 0, cycles = 0, n, took, len;
    int                          modes[4] = '{1, 2, 4, 5};
    assign sig = {spk, tout};

    interval_timer u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .io_wr_in(req.wr), .io_rd_in(req.rd),
        .io_addr_in(req.addr), .io_wdata_in(req.wdata), .speaker_gate_enable_in(spk_en),
        .tone_counter_gate_enable_in(tone_en), .io_rdata_out(rdata), .timer_out_out(tout),
        .speaker_tone_output_out(spk));
    io_host_model u_host (.clk_in(mclk), .rdata_in(rdata), .req_out(req));

    function automatic logic [7:0] rb_cmd(input logic cnt_n, input logic stat_n, input logic [1:0] ctr);
        return {2'b11, cnt_n, stat_n, 3'(3'h1 << ctr), 1'b0};
    endfunction : rb_cmd
    function automatic logic [7:0] status_byte(input logic o, input logic nul, input logic [2:0] mode);
        return {o, nul, interval_timer_pkg::FMT_BOTH, mode, 1'b0};
    endfunction : status_byte

    task automatic wait_level(input int b, input logic lvl, input int limit, output int t);
        t = 0;
        while (sig[b] !== lvl && t < limit) begin
            t++;
            @(negedge mclk);
        end
    endtask : wait_level
    task automatic run_len(input int b, input logic lvl, input int limit, output int t);
        t = 0;
        while (sig[b] === lvl && t < limit) begin
            t++;
            @(negedge mclk);
        end
    endtask : run_len
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Whole run is well under this ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        spk_en = 1'b1;
        tone_en = 1'b1;
        n = $urandom(374);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        `CHECK(spk, 1'b0)
        u_host.wr_byte(8'h44, 8'hff);
        u_host.rd_byte(8'h44, st);
        `CHECK(st, 8'h00)
        u_host.rd_byte(interval_timer_pkg::timer_command_port, st);
        `CHECK(st, 8'h00)
        n = 5 + ($urandom % 12);
        u_host.program_counter(2'd0, 3'd0, 16'(n));
        @(negedge mclk);
        `CHECK(tout[0], 1'b0)
        wait_level(0, 1'b1, (n + 4) * 12, took);
        `CHECK((took >= (n - 2) * 12) && (took < (n + 4) * 12), 1'b1)
        run_len(0, 1'b1, 200, len);
        `CHECK(len, 200)
        foreach (modes[i]) begin
            n = 3 + ($urandom % 10);
            u_host.program_counter(2'd0, 3'(modes[i]), 16'(n));
            wait_level(0, modes[i] == 1, (n + 4) * 12, took);
            `CHECK(took < (n + 4) * 12, 1'b1)
            run_len(0, modes[i] == 1, 100, len);
            `CHECK(len, 12)
        end
        // Decimal count of 10 must expire after ten ticks, not sixteen
        u_host.wr_byte(interval_timer_pkg::timer_command_port, 8'h31);
        u_host.wr_byte(interval_timer_pkg::counter0_data_port, 8'h10);
        u_host.wr_byte(interval_timer_pkg::counter0_data_port, 8'h00);
        wait_level(0, 1'b1, 14 * 12, took);
        `CHECK((took >= 9 * 12) && (took < 13 * 12), 1'b1)
        u_host.program_counter(2'd1, 3'd2, 16'h1234);
        repeat (40) @(negedge mclk);
        u_host.wr_byte(8'h43, {2'd1, interval_timer_pkg::FMT_LATCH, 4'h0});
        repeat (60) @(negedge mclk);
        u_host.wr_byte(8'h43, {2'd1, interval_timer_pkg::FMT_LATCH, 4'h0});
        u_host.rd_byte(8'h41, v1[7:0]);
        u_host.rd_byte(8'h40, st);
        u_host.rd_byte(8'h41, v1[15:8]);
        u_host.rd_word(2'd1, v2);
        `CHECK((v1 <= 16'h1234) && (v1 > v2 + 16'd4), 1'b1)
        u_host.program_counter(2'd1, 3'd2, 16'h0800);
        repeat (40) @(negedge mclk);
        u_host.wr_byte(8'h43, rb_cmd(1'b0, 1'b0, 2'd1));
        repeat (36) @(negedge mclk);
        u_host.wr_byte(8'h43, rb_cmd(1'b0, 1'b0, 2'd1));
        u_host.rd_byte(8'h41, st);
        `CHECK(st, status_byte(1'b1, 1'b0, 3'd2))
        u_host.rd_word(2'd1, v1);
        u_host.rd_word(2'd1, v2);
        `CHECK((v1 <= 16'h0800) && (v1 > v2 + 16'd2), 1'b1)
        u_host.wr_byte(8'h41, 8'h00);
        u_host.wr_byte(8'h41, 8'h09);
        repeat (40) @(negedge mclk);
        u_host.wr_byte(8'h43, rb_cmd(1'b1, 1'b0, 2'd1));
        u_host.rd_byte(8'h41, st);
        `CHECK(st, status_byte(1'b1, 1'b0, 3'd2))
        n = 2 * (2 + ($urandom % 8));
        u_host.program_counter(2'd2, 3'd3, 16'(n));
        wait_level(2, 1'b0, (n + 4) * 12, took);
        run_len(2, 1'b0, 1000, len);
        `CHECK(len, n * 6)
        run_len(2, 1'b1, 1000, len);
        `CHECK(len, n * 6)
        wait_level(3, 1'b0, n * 12, took);
        run_len(3, 1'b0, 1000, len);
        `CHECK(len, n * 6)
        @(posedge mclk);
        spk_en <= 1'b0;
        repeat (6) @(negedge mclk);
        run_len(3, 1'b0, n * 24, len);
        `CHECK(len, n * 24)
        @(posedge mclk);
        tone_en <= 1'b0;
        repeat (6) @(negedge mclk);
        run_len(2, sig[2], n * 36, len);
        `CHECK(len, n * 36)
        tally_and_finish();
    end
endmodule : testbench
